//--- design/dsrc_pkg.sv
// Package: constants and types for the start/restart/emergency control
package dsrc_pkg;
    // ------------------------------------------------------------
    // Start mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] START_EDGE = 3'h0;
    localparam logic [2:0] START_AUTO = 3'h1;
    localparam logic [2:0] START_RETRY_MAX = 3'h6;

    // ------------------------------------------------------------
    // Selection ranges
    // ------------------------------------------------------------
    localparam logic [4:0] FIRE_FUNC_LO = 5'h0f;
    localparam logic [4:0] FIRE_FUNC_HI = 5'h12;
    localparam logic [3:0] CTRL_KP_LO = 4'h1;
    localparam logic [3:0] CTRL_KP_HI = 4'h4;

    // ------------------------------------------------------------
    // Start speed encodings
    // ------------------------------------------------------------
    localparam logic [1:0] SPD_MIN = 2'h0;
    localparam logic [1:0] SPD_PREV = 2'h1;
    localparam logic [1:0] SPD_CUR = 2'h2;
    localparam logic [1:0] SPD_PRESET4 = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    localparam int RETRY_GAP_S = 20;
    localparam int RETRY_GAP_TICKS = RETRY_GAP_S * (1000000000 / TICK_PERIOD_NS);

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [2:0] RETRY_COUNT_RST = 3'h0;

    typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_LOCK} dsrc_state_t;
endpackage

//--- design/dsrc_tmr_if.sv
// Interface: link between control core and restart spacing timer
`timescale 1ns/100ps
interface dsrc_tmr_if;
    logic clear;
    logic done;
    modport ctrl (output clear, input done);
    modport tmr (input clear, output done);
endinterface

//--- design/dsrc_retry_timer.sv
// Restart spacing timer on a fixed timebase tick
`timescale 1ns/100ps
module dsrc_retry_timer
    import dsrc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int GAP_TICKS = RETRY_GAP_TICKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    dsrc_tmr_if.tmr tif
);
    typedef struct packed {
        logic [31:0] pre;
        logic [31:0] ticks;
        logic done;
    } dsrc_tmr_state_t;

    dsrc_tmr_state_t r;
    dsrc_tmr_state_t next_r;

    // ------------------------------------------------------------
    // Tick and interval counting
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (tif.clear) begin
            next_r = '0;
        end else if (!r.done) begin
            if (r.pre == 32'(TICK_CYC - 1)) begin
                next_r.pre = '0;
                next_r.ticks = r.ticks + 32'h1;
                if (r.ticks == 32'(GAP_TICKS - 1)) begin
                    next_r.done = 1'b1;
                end
            end else begin
                next_r.pre = r.pre + 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tif.done = r.done;
endmodule // dsrc_retry_timer

//--- design/dsrc_ctrl.sv
// Top: run-command qualification, auto restart and emergency override
`timescale 1ns/100ps
// Contract
// - Edge mode: need open-then-close after reset
// - Level auto mode: start at once if closed
// - Retries 1-5, spaced 20 s apart
// - Count attempts; final failure locks until user reset
// - Counter cleared only by power-down
// - Emergency settings apply for functions 15-18
// - Polarity 0: override while input open
// - Polarity 1: override while input closed
// - Latch 0: override follows active input
// - Latch 1: pulse holds override until disabled
// - Keypad start mode only for sources 1-4
// - Modes 0,1,4,5: keypad keys, terminals linked
// - Modes 2,3,6,7: terminal start, keys ignored
// - Mode 0 starts at minimum speed
// - Mode 1 starts at previous speed
// - Modes 4-7: current or preset-4 speed
// - Override taken from third digital input
module dsrc_ctrl
    import dsrc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int GAP_TICKS = RETRY_GAP_TICKS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic [2:0] start_mode,
    input wire logic [4:0] input_func,
    input wire logic fire_polarity,
    input wire logic fire_latch,
    input wire logic [3:0] ctrl_src,
    input wire logic [2:0] kp_start_mode,
    // Pins
    input wire logic din1,
    input wire logic din3,
    input wire logic kp_start_key,
    input wire logic kp_stop_key,
    // Drive events
    input wire logic trip_in,
    input wire logic fault_reset,
    // Status and commands
    output logic run_cmd,
    output logic fire_mode,
    output logic fault_lock,
    output logic [2:0] retry_count,
    output logic [1:0] speed_sel,
    output logic terminal_start
);
    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic fire_func_sel(input logic [4:0] f);
        return (f >= FIRE_FUNC_LO) && (f <= FIRE_FUNC_HI);
    endfunction

    function automatic logic keypad_src(input logic [3:0] s);
        return (s >= CTRL_KP_LO) && (s <= CTRL_KP_HI);
    endfunction

    function automatic logic [2:0] retry_limit(input logic [2:0] m);
        if ((m > START_AUTO) && (m <= START_RETRY_MAX)) begin
            return m - START_AUTO;
        end
        return 3'h0;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic din1_m;
        logic din1;
        logic din3_m;
        logic din3;
        logic kstart_m;
        logic kstart;
        logic kstart_d;
        logic kstop_m;
        logic kstop;
        logic [1:0] settle;
        logic armed;
        logic kp_run;
        dsrc_state_t state;
        logic [2:0] retry_count;
        logic run_cmd;
        logic fire_mode;
        logic fault_lock;
        logic [1:0] speed_sel;
        logic terminal_start;
    } dsrc_ctrl_state_t;

    dsrc_ctrl_state_t r;
    dsrc_ctrl_state_t next_r;
    dsrc_tmr_if tif ();

    // ------------------------------------------------------------
    // Restart spacing timer
    // ------------------------------------------------------------
    assign tif.clear = (r.state != ST_WAIT);

    dsrc_retry_timer #(
        .TICK_CYC(TICK_CYC),
        .GAP_TICKS(GAP_TICKS)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic use_term;
        logic want_run;
        logic fire_act;
        use_term = 1'b0;
        want_run = 1'b0;
        fire_act = 1'b0;
        next_r = r;

        // Input synchronisers
        next_r.din1_m = din1;
        next_r.din1 = r.din1_m;
        next_r.din3_m = din3;
        next_r.din3 = r.din3_m;
        next_r.kstart_m = kp_start_key;
        next_r.kstart = r.kstart_m;
        next_r.kstart_d = r.kstart;
        next_r.kstop_m = kp_stop_key;
        next_r.kstop = r.kstop_m;
        // Synchroniser fill after reset
        next_r.settle = {r.settle[0], 1'b1};

        // Start source selection
        use_term = !keypad_src(ctrl_src) || kp_start_mode[1];
        if (use_term) begin
            next_r.kp_run = 1'b0;
        end else if (r.kstop || !r.din1) begin
            next_r.kp_run = 1'b0;
        end else if (r.kstart && !r.kstart_d) begin
            next_r.kp_run = 1'b1;
        end

        // Start speed
        if (!keypad_src(ctrl_src)) begin
            next_r.speed_sel = SPD_CUR;
        end else begin
            case (kp_start_mode)
                3'h0, 3'h2: next_r.speed_sel = SPD_MIN;
                3'h1, 3'h3: next_r.speed_sel = SPD_PREV;
                3'h4, 3'h6: next_r.speed_sel = SPD_CUR;
                default: next_r.speed_sel = SPD_PRESET4;
            endcase
        end
        next_r.terminal_start = use_term;

        // Start arming after reset
        if ((start_mode != START_EDGE) || (r.settle[1] && !r.din1)) begin
            next_r.armed = 1'b1;
        end

        // Trip and restart sequencing
        case (r.state)
            ST_RUN: begin
                if (trip_in) begin
                    if (r.retry_count < retry_limit(start_mode)) begin
                        next_r.state = ST_WAIT;
                    end else begin
                        next_r.state = ST_LOCK;
                    end
                end
            end
            ST_WAIT: begin
                if (tif.done) begin
                    next_r.retry_count = r.retry_count + 3'h1;
                    next_r.state = ST_RUN;
                end
            end
            ST_LOCK: begin
                if (fault_reset) begin
                    next_r.state = ST_RUN;
                    next_r.armed = 1'b0;
                end
            end
            default: begin
                next_r.state = ST_LOCK;
            end
        endcase
        next_r.fault_lock = (next_r.state == ST_LOCK);

        // Run command
        want_run = use_term ? r.din1 : r.kp_run;
        next_r.run_cmd = (r.state == ST_RUN) && r.armed && want_run;

        // Emergency override
        fire_act = r.settle[1] && (fire_polarity ? r.din3 : !r.din3);
        if (!fire_func_sel(input_func)) begin
            next_r.fire_mode = 1'b0;
        end else if (fire_latch) begin
            next_r.fire_mode = r.fire_mode || fire_act;
        end else begin
            next_r.fire_mode = fire_act;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.state <= ST_RUN;
            r.retry_count <= RETRY_COUNT_RST;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign run_cmd = r.run_cmd;
    assign fire_mode = r.fire_mode;
    assign fault_lock = r.fault_lock;
    assign retry_count = r.retry_count;
    assign speed_sel = r.speed_sel;
    assign terminal_start = r.terminal_start;
endmodule // dsrc_ctrl

//--- tb/dsrc_ctrl_props.sv
// Checker: port-level properties of the start/restart control
`timescale 1ns/100ps
module dsrc_ctrl_props
    import dsrc_pkg::*;
#(
    parameter int TICK_CYC = 4,
    parameter int GAP_TICKS = 5
) (
    // Watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] input_func,
    input wire logic fire_polarity,
    input wire logic fire_latch,
    input wire logic [3:0] ctrl_src,
    input wire logic [2:0] kp_start_mode,
    input wire logic din3,
    input wire logic fault_reset,
    input wire logic run_cmd,
    input wire logic fire_mode,
    input wire logic fault_lock,
    input wire logic [2:0] retry_count,
    input wire logic [1:0] speed_sel,
    input wire logic terminal_start
);
    logic fen;
    logic kp;
    assign fen = input_func inside {[FIRE_FUNC_LO:FIRE_FUNC_HI]};
    assign kp = ctrl_src inside {[CTRL_KP_LO:CTRL_KP_HI]};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_lock_clear: assert property (fault_lock && fault_reset |=> !fault_lock)
        else $error("fault lock not cleared");
    chk_count_kept: assert property (fault_lock && fault_reset |=> $stable(retry_count))
        else $error("retry count changed by fault reset");
    chk_count_max: assert property (retry_count <= 3'h5)
        else $error("retry count above five");
    chk_fire_func: assert property (!fen |=> !fire_mode)
        else $error("override outside enabling functions");
    chk_nc_active: assert property ((fen && !fire_polarity && !din3)[*5] |-> fire_mode)
        else $error("open contact not overriding");
    chk_no_active: assert property ((fen && fire_polarity && din3)[*5] |-> fire_mode)
        else $error("closed contact not overriding");
    chk_follow_off: assert property (
        (fen && !fire_latch && din3 != fire_polarity && $stable(fire_polarity))[*5]
        |-> !fire_mode) else $error("override kept after input inactive");
    chk_latch_hold: assert property (fire_mode && fire_latch && fen |=> fire_mode)
        else $error("latched override dropped");
    chk_term_src: assert property (!kp |=> terminal_start)
        else $error("keypad mode used with terminal source");
    chk_key_modes: assert property (kp |=> terminal_start == $past(kp_start_mode[1]))
        else $error("start source wrong for keypad mode");
    chk_speed_min: assert property (kp && kp_start_mode == 3'h0 |=> speed_sel == SPD_MIN)
        else $error("mode zero not at minimum speed");
    cover property (fault_lock);
    cover property (fire_mode && fire_latch);
    cover property (run_cmd && !terminal_start);
endmodule // dsrc_ctrl_props

//--- tb/dsrc_partner.sv
// Partner model: keypad, terminal switches and fire contact
`timescale 1ns/100ps
module dsrc_partner (
    // Operator and fire system commands
    input wire logic sw1,
    input wire logic sw3,
    input wire logic start_btn,
    input wire logic stop_btn,
    // Pins toward the drive
    output logic din1,
    output logic din3,
    output logic kp_start_key,
    output logic kp_stop_key
);
    assign din1 = sw1;
    assign din3 = sw3;
    assign kp_start_key = start_btn;
    assign kp_stop_key = stop_btn;
endmodule // dsrc_partner

//--- tb/dsrc_ctrl_tb.sv
// Testbench: directed sequences for the start/restart control
`timescale 1ns/100ps
module dsrc_ctrl_tb;
    import dsrc_pkg::*;
    logic clk = 0, rst = 1, sw1, sw3, start_btn, stop_btn, trip_in, fault_reset;
    logic [2:0] start_mode, kp_start_mode, retry_count;
    logic [4:0] input_func;
    logic [3:0] ctrl_src;
    logic [1:0] speed_sel;
    logic fire_polarity, fire_latch, din1, din3, kp_start_key, kp_stop_key;
    logic run_cmd, fire_mode, fault_lock, terminal_start;
    int fails = 0, num_checks = 0, cycles = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    dsrc_partner dsrc_partner_i (.sw1, .sw3, .start_btn, .stop_btn, .din1, .din3,
        .kp_start_key, .kp_stop_key);
    dsrc_ctrl #(.TICK_CYC(4), .GAP_TICKS(5)) dsrc_ctrl_i (.clk, .rst, .start_mode,
        .input_func, .fire_polarity, .fire_latch, .ctrl_src, .kp_start_mode, .din1, .din3,
        .kp_start_key, .kp_stop_key, .trip_in, .fault_reset, .run_cmd, .fire_mode,
        .fault_lock, .retry_count, .speed_sel, .terminal_start);
    task automatic chk(input string name, input logic [2:0] seen, input logic [2:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {start_mode, input_func, fire_polarity, fire_latch, ctrl_src, kp_start_mode} = '0;
        {sw1, sw3, start_btn, stop_btn, trip_in, fault_reset} = 6'h20;
        wt(4);
        rst = 0;
        wt(10);
        chk("edge held", run_cmd, 3'h0);
        sw1 = 0;
        wt(5);
        sw1 = 1;
        wt(5);
        chk("edge run", run_cmd, 3'h1);
        start_mode = 3'h1;
        rst = 1;
        wt(3);
        rst = 0;
        wt(6);
        chk("auto run", run_cmd, 3'h1);
        start_mode = 3'h3;
        for (int i = 1; i <= 3; i++) begin
            trip_in = 1;
            wt(1);
            trip_in = 0;
            wt(20);
            chk("gap idle", run_cmd, 3'h0);
            wt(6);
            chk("count", retry_count, (i < 3) ? i[2:0] : 3'h2);
            chk("rerun", run_cmd, i < 3);
            chk("lock", fault_lock, i == 3);
        end
        fault_reset = 1;
        wt(1);
        fault_reset = 0;
        wt(2);
        chk("unlock", fault_lock, 3'h0);
        chk("count kept", retry_count, 3'h2);
        rst = 1;
        wt(3);
        rst = 0;
        wt(1);
        chk("count clear", retry_count, 3'h0);
        for (int k = 0; k < 4; k++) begin
            input_func = 5'h00;
            {fire_latch, fire_polarity} = k[1:0];
            sw3 = k[0];
            wt(5);
            chk("func off", fire_mode, 3'h0);
            sw3 = !k[0];
            wt(4);
            input_func = 5'h0f + k[4:0];
            wt(6);
            chk("idle", fire_mode, 3'h0);
            sw3 = k[0];
            wt(6);
            chk("active", fire_mode, 3'h1);
            sw3 = !k[0];
            wt(6);
            chk("release", fire_mode, k[1]);
        end
        ctrl_src = 4'h1;
        for (int m = 0; m < 8; m++) begin
            kp_start_mode = m[2:0];
            wt(3);
            chk("term", terminal_start, m[1]);
            chk("speed", speed_sel, {m[2], m[0]});
        end
        ctrl_src = 4'h0;
        wt(3);
        chk("src term", terminal_start, 3'h1);
        ctrl_src = 4'h1;
        kp_start_mode = 3'h0;
        stop_btn = 1;
        wt(5);
        stop_btn = 0;
        wt(5);
        chk("stopped", run_cmd, 3'h0);
        start_btn = 1;
        wt(5);
        start_btn = 0;
        wt(2);
        chk("key run", run_cmd, 3'h1);
        stop_btn = 1;
        wt(5);
        chk("key stop", run_cmd, 3'h0);
        kp_start_mode = 3'h2;
        wt(5);
        chk("keys ignored", run_cmd, 3'h1);
        stop_test();
    end
endmodule // dsrc_ctrl_tb
bind dsrc_ctrl dsrc_ctrl_props #(.TICK_CYC(TICK_CYC), .GAP_TICKS(GAP_TICKS)) dsrc_ctrl_props_i (
    .clk, .rst, .input_func, .fire_polarity, .fire_latch, .ctrl_src, .kp_start_mode, .din3,
    .fault_reset, .run_cmd, .fire_mode, .fault_lock, .retry_count, .speed_sel,
    .terminal_start);
